// file: logic/cifd_pkg.sv
// Package for the core instruction field decoder: field layout and timing
package cifd_pkg;
	// ----------------------------------------
	// Instruction word layout
	// ----------------------------------------
	localparam int WORD_W = 14;
	localparam int FADDR_LSB = 0;
	localparam int FADDR_W = 7;
	localparam int DEST_POS = 7;
	localparam int BITSEL_LSB = 7;
	localparam int BITSEL_W = 3;
	localparam int LIT8_W = 8;
	localparam int LIT11_W = 11;
	localparam int OPC_MSB = 13;
	// Group codes in the two top bits
	localparam logic [1:0] GRP_BYTE = 2'h0;
	localparam logic [1:0] GRP_BIT = 2'h1;
	localparam logic [1:0] GRP_JUMP = 2'h2;
	localparam logic [1:0] GRP_LIT = 2'h3;
	// Bit-op subcodes in bits 11:10 (skip ops are 2 and 3)
	localparam logic [1:0] BITOP_SKIP0 = 2'h2;
	// Byte-op code of the no-operation word
	localparam logic [WORD_W-1:0] NOP_WORD = 14'h0000;
	// Address of the second I/O port, which has change detect
	localparam logic [FADDR_W-1:0] PORT2_ADDR = 7'h06;
	// Address of the program counter low byte; a write there redirects
	localparam logic [FADDR_W-1:0] PC_ADDR = 7'h02;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int OSC_PER_CYCLE = 4;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam logic [1:0] PHASE_READ = 2'h1;
	localparam logic [1:0] PHASE_WRITE = 2'h3;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		CIFD_GROUP_BYTE,
		CIFD_GROUP_BIT,
		CIFD_GROUP_LIT
	} cifd_group_t;

	// Decoded fields travel together
	typedef struct packed {
		cifd_group_t group;
		logic [5:0] opcode;
		logic [6:0] faddr;
		logic dest_file;
		logic [2:0] bitsel;
		logic [10:0] literal;
		logic is_jump;
		logic uses_file;
	} cifd_fields_t;
endpackage : cifd_pkg

// file: logic/cifd_decoder.sv
// Instruction field decoder with four-phase cycle and read-modify-write
`timescale 1ns/1ns
// ----------------------------------------
// Functional notes
// ----------------------------------------
module cifd_decoder (
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Fetched instruction, taken at cycle start
	input wire logic [13:0] instr_in,
	// Result of the skip test, valid at the write phase
	input wire logic skip_true_in,
	// Decoded fields of the executing instruction
	output cifd_pkg::cifd_fields_t fields_out,
	// Cycle timing
	output logic [1:0] phase_out,
	output logic cycle_start_out,
	output logic nop_cycle_out,
	// File register access strobes
	output logic file_rd_out,
	output logic file_wr_out,
	output logic w_wr_out,
	output logic [6:0] file_addr_out,
	// Clears the change mismatch of the second I/O port
	output logic port2_mismatch_clr_out
);
	// ----------------------------------------
	// Combinational decode
	// ----------------------------------------
	cifd_pkg::cifd_fields_t next_fields;
	logic next_extra;
	logic [1:0] next_phase;

	// Splits the word; address, bit select and opcode are taken from every word, whatever its group
	always_comb begin
		next_fields = '0;
		next_fields.faddr = instr_in[cifd_pkg::FADDR_LSB +:
			cifd_pkg::FADDR_W];
		next_fields.bitsel = instr_in[cifd_pkg::BITSEL_LSB +:
			cifd_pkg::BITSEL_W];
		next_fields.opcode = instr_in[cifd_pkg::OPC_MSB -: 6];
		case (instr_in[13:12])
			cifd_pkg::GRP_BYTE: begin
				next_fields.group = cifd_pkg::CIFD_GROUP_BYTE;
				next_fields.dest_file = instr_in[cifd_pkg::DEST_POS];
				// Control words (return, sleep) have a zero address field
				next_fields.uses_file = (instr_in[6:0] != 7'h00) ||
					instr_in[11:8] != 4'h0;
			end
			cifd_pkg::GRP_BIT: begin
				next_fields.group = cifd_pkg::CIFD_GROUP_BIT;
				next_fields.dest_file = 1'b1;
				next_fields.uses_file = 1'b1;
			end
			cifd_pkg::GRP_JUMP: begin
				next_fields.group = cifd_pkg::CIFD_GROUP_LIT;
				next_fields.literal = instr_in[10:0];
				next_fields.is_jump = 1'b1;
			end
			default: begin
				next_fields.group = cifd_pkg::CIFD_GROUP_LIT;
				// Upper literal bits are don't-care and forced to zero
				next_fields.literal = {3'h0, instr_in[7:0]};
			end
		endcase
	end

	assign next_phase = phase_out + 2'h1;

	// Extra NOP cycle: jumps, byte-op writes to PC (addr 2), or true skips
	always_comb begin
		next_extra = fields_out.is_jump ||
			(fields_out.uses_file && fields_out.dest_file &&
			fields_out.group == cifd_pkg::CIFD_GROUP_BYTE &&
			fields_out.faddr == cifd_pkg::PC_ADDR) ||
			skip_true_in;
	end

	// ----------------------------------------
	// Phase counter
	// ----------------------------------------
	// Four clock periods make one instruction cycle
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			phase_out <= 2'h0;
			cycle_start_out <= 1'b0;
		end else begin
			phase_out <= next_phase;
			cycle_start_out <= (next_phase == cifd_pkg::PHASE_LAST);
		end
	end

	// ----------------------------------------
	// Instruction latch and NOP insertion
	// ----------------------------------------
	// A flushed cycle runs as a NOP word so it has no side effects
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			fields_out <= '0;
			nop_cycle_out <= 1'b0;
		end else if (phase_out == cifd_pkg::PHASE_LAST) begin
			if (next_extra && !nop_cycle_out) begin
				fields_out <= '0;
				nop_cycle_out <= 1'b1;
			end else begin
				fields_out <= next_fields;
				nop_cycle_out <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Read-modify-write strobes
	// ----------------------------------------
	// Read in phase 1 always precedes the write in phase 3
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			file_rd_out <= 1'b0;
			file_wr_out <= 1'b0;
			w_wr_out <= 1'b0;
			file_addr_out <= 7'h00;
			port2_mismatch_clr_out <= 1'b0;
		end else begin
			file_addr_out <= fields_out.faddr;
			file_rd_out <= fields_out.uses_file &&
				next_phase == cifd_pkg::PHASE_READ;
			port2_mismatch_clr_out <= fields_out.uses_file &&
				next_phase == cifd_pkg::PHASE_READ &&
				fields_out.faddr == cifd_pkg::PORT2_ADDR;
			// Skip bit-tests write nothing back
			file_wr_out <= fields_out.uses_file && fields_out.dest_file &&
				!(fields_out.group == cifd_pkg::CIFD_GROUP_BIT &&
				fields_out.opcode[3]) &&
				next_phase == cifd_pkg::PHASE_WRITE;
			w_wr_out <= fields_out.uses_file && !fields_out.dest_file &&
				next_phase == cifd_pkg::PHASE_WRITE;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_PHASE_WRAPS: assert property (@(posedge clk_in)
		disable iff (!arst_n_in) cycle_start_out |=> ##3 cycle_start_out)
		else $error("cycle start not every four clocks");
	// The first edge after release still shows the reset phase
	AST_PHASE_STEP: assert property (@(posedge clk_in)
		disable iff (!arst_n_in) $past(arst_n_in) |->
		phase_out == 2'($past(phase_out) + 2'h1))
		else $error("phase did not advance");
	AST_READ_BEFORE_WRITE: assert property (@(posedge clk_in)
		disable iff (!arst_n_in) file_wr_out |-> $past(file_rd_out, 2))
		else $error("file write without earlier read");
	AST_W_DEST: assert property (@(posedge clk_in)
		disable iff (!arst_n_in) !(file_wr_out && w_wr_out))
		else $error("both destinations written");
	AST_DEST_ZERO: assert property (@(posedge clk_in)
		disable iff (!arst_n_in) w_wr_out |-> !fields_out.dest_file)
		else $error("W written with dest bit one");
	AST_PORT_CLR: assert property (@(posedge clk_in)
		disable iff (!arst_n_in) port2_mismatch_clr_out |->
		file_rd_out && file_addr_out == cifd_pkg::PORT2_ADDR)
		else $error("mismatch clear without port read");
	AST_JUMP_NOP: assert property (@(posedge clk_in)
		disable iff (!arst_n_in)
		(phase_out == 2'h3 && fields_out.is_jump && !nop_cycle_out)
		|=> nop_cycle_out ##4 !nop_cycle_out)
		else $error("jump missing single NOP cycle");
	AST_LIT_WIDTH: assert property (@(posedge clk_in)
		disable iff (!arst_n_in)
		(fields_out.group == cifd_pkg::CIFD_GROUP_LIT &&
		!fields_out.is_jump) |-> fields_out.literal[10:8] == 3'h0)
		else $error("literal wider than eight bits");
	AST_NOP_QUIET: assert property (@(posedge clk_in)
		disable iff (!arst_n_in)
		nop_cycle_out |-> !file_wr_out && !w_wr_out)
		else $error("NOP cycle wrote a result");
	// Each strobe lands in its own phase and stands one clock
	AST_RD_PHASE: assert property (@(posedge clk_in)
		disable iff (!arst_n_in)
		file_rd_out |-> phase_out == cifd_pkg::PHASE_READ)
		else $error("file read outside the read phase");
	AST_WR_PHASE: assert property (@(posedge clk_in)
		disable iff (!arst_n_in)
		(file_wr_out || w_wr_out) |-> phase_out == cifd_pkg::PHASE_WRITE)
		else $error("result stored outside the write phase");
	AST_STROBE_PULSE: assert property (@(posedge clk_in)
		disable iff (!arst_n_in)
		(file_rd_out || file_wr_out) |=> !file_rd_out && !file_wr_out)
		else $error("file strobe stood longer than one clock");
	// Decoded fields only move at the start of an instruction cycle
	AST_FIELDS_STABLE: assert property (@(posedge clk_in)
		disable iff (!arst_n_in)
		phase_out != 2'h0 |-> $stable(fields_out))
		else $error("decoded fields changed inside a cycle");
	AST_SKIP_NOP: assert property (@(posedge clk_in)
		disable iff (!arst_n_in)
		(phase_out == cifd_pkg::PHASE_LAST && skip_true_in &&
		!nop_cycle_out) |=> nop_cycle_out && fields_out == '0)
		else $error("true skip without a NOP cycle");
	AST_PC_WRITE_NOP: assert property (@(posedge clk_in)
		disable iff (!arst_n_in)
		(phase_out == cifd_pkg::PHASE_LAST && !nop_cycle_out &&
		file_wr_out && file_addr_out == cifd_pkg::PC_ADDR &&
		fields_out.group == cifd_pkg::CIFD_GROUP_BYTE)
		|=> nop_cycle_out)
		else $error("program counter write without a NOP cycle");
	AST_NOP_ONCE: assert property (@(posedge clk_in)
		disable iff (!arst_n_in)
		(phase_out == cifd_pkg::PHASE_LAST && nop_cycle_out)
		|=> !nop_cycle_out)
		else $error("two NOP cycles in a row");
	COV_JUMP: cover property (@(posedge clk_in) disable iff (!arst_n_in)
		fields_out.is_jump ##1 nop_cycle_out);
	COV_FILE_WR: cover property (@(posedge clk_in) disable iff (!arst_n_in)
		file_wr_out);
	COV_W_WR: cover property (@(posedge clk_in) disable iff (!arst_n_in)
		w_wr_out);
	COV_PORT: cover property (@(posedge clk_in) disable iff (!arst_n_in)
		port2_mismatch_clr_out);
	COV_SKIP: cover property (@(posedge clk_in) disable iff (!arst_n_in)
		skip_true_in && phase_out == cifd_pkg::PHASE_LAST ##1 nop_cycle_out);
endmodule : cifd_decoder

// file: testbench/cifd_file_model.sv
// Behavioural data file registers facing the decoder strobes
`timescale 1ns/1ns
module cifd_file_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Strobes and address from the decoder
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic [6:0] addr_in,
	// Reads seen, writes to a register not read first
	output int rd_cnt_out,
	output int bad_wr_out
);
	logic [6:0] last_rd; // Address of the latest read
	// A store must land on the register read earlier in the cycle
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_cnt_out <= 0;
			bad_wr_out <= 0;
			last_rd <= 7'h00;
		end else begin
			if (rd_in) begin
				rd_cnt_out <= rd_cnt_out + 1;
				last_rd <= addr_in;
			end
			if (wr_in && addr_in !== last_rd) bad_wr_out <= bad_wr_out + 1;
		end
	end
endmodule : cifd_file_model

// file: testbench/core_instruction_field_decode_tb.sv
// Self-checking bench for the instruction field decoder
`timescale 1ns/1ns
module core_instruction_field_decode_tb;
	// Expected outcome of one executed word
	typedef struct packed {
		cifd_pkg::cifd_group_t grp;
		logic jmp, dest, rd, wf, ww, clr;
		logic [6:0] fa;
		logic [2:0] bs;
		logic [10:0] lit;
		logic [5:0] op;
	} cifd_exp_t;
	logic clk_in = 0, arst_n_in = 0, skip_true_in = 0;
	logic [13:0] instr_in = 14'h0000;
	cifd_pkg::cifd_fields_t fields_out;
	logic [1:0] phase_out;
	logic cyc_s, nop_c, f_rd, f_wr, w_wr, p2_clr;
	logic [6:0] f_addr;
	int error_cnt = 0, checks = 0, exp_nops = 0, nops = 0, exp_rd = 0;
	int rd_cnt, bad_wr;
	logic [31:0] seed = 32'h0000001D; // Fixed start of the xorshift
	cifd_exp_t q[$], cur;
	always #20 clk_in = ~clk_in;
	cifd_decoder dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.instr_in(instr_in), .skip_true_in(skip_true_in),
		.fields_out(fields_out), .phase_out(phase_out),
		.cycle_start_out(cyc_s), .nop_cycle_out(nop_c), .file_rd_out(f_rd),
		.file_wr_out(f_wr), .w_wr_out(w_wr), .file_addr_out(f_addr),
		.port2_mismatch_clr_out(p2_clr));
	cifd_file_model fm (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.rd_in(f_rd), .wr_in(f_wr), .addr_in(f_addr),
		.rd_cnt_out(rd_cnt), .bad_wr_out(bad_wr));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	// Offer a word on the edge before the taking edge, note its outcome
	task automatic put(input logic [13:0] w, input logic sk, input bit push);
		cifd_exp_t e;
		// Phase is read at the falling edge, where it has settled
		@(negedge clk_in);
		for (int i = 0; i < 4 && phase_out !== 2'h2; i++) @(negedge clk_in);
		@(posedge clk_in);
		instr_in <= w;
		skip_true_in <= sk;
		e = '0;
		e.grp = w[13] ? cifd_pkg::CIFD_GROUP_LIT :
			(w[12] ? cifd_pkg::CIFD_GROUP_BIT : cifd_pkg::CIFD_GROUP_BYTE);
		e.jmp = (w[13:12] == 2'h2);
		{e.fa, e.dest, e.bs} = {w[6:0], w[7], w[9:7]};
		e.lit = e.jmp ? w[10:0] : {3'h0, w[7:0]};
		e.op = w[13:8];
		e.rd = !w[13] && (w[12] || w[11:8] != 4'h0 || w[6:0] != 7'h00);
		e.wf = e.rd && (w[12] ? !w[11] : w[7]);
		e.ww = e.rd && !w[12] && !w[7];
		e.clr = e.rd && (w[6:0] == 7'h06);
		if (push) q.push_back(e);
		if (push) exp_rd += e.rd;
	endtask : put
	// ----------------------------------------
	// Output watcher
	// ----------------------------------------
	// Sampled mid-cycle so every edge update has landed
	always @(negedge clk_in) if (arst_n_in) begin
		if (phase_out === 2'h0) begin
			cur = '0;
			if (nop_c === 1'b1) nops++;
			else if (q.size() > 0) begin
				cur = q.pop_front();
				chk(fields_out.group, cur.grp);
				chk(fields_out.is_jump, cur.jmp);
				chk(fields_out.opcode, cur.op);
				chk(fields_out.uses_file, cur.rd);
				if (cur.grp != cifd_pkg::CIFD_GROUP_LIT) chk(fields_out.faddr, cur.fa);
				if (cur.grp == cifd_pkg::CIFD_GROUP_BYTE) chk(fields_out.dest_file, cur.dest);
				if (cur.grp == cifd_pkg::CIFD_GROUP_BIT) chk(fields_out.bitsel, cur.bs);
				if (cur.grp == cifd_pkg::CIFD_GROUP_LIT) chk(fields_out.literal, cur.lit);
			end
		end
		chk(cyc_s, phase_out === 2'h3);
		if (phase_out === 2'h1) chk(f_rd, cur.rd);
		if (phase_out === 2'h1) chk(p2_clr, cur.clr);
		if (phase_out === 2'h3) chk(f_wr, cur.wf);
		if (phase_out === 2'h3 && cur.grp == cifd_pkg::CIFD_GROUP_BYTE) chk(w_wr, cur.ww);
	end
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		logic [13:0] w;
		logic [6:0] f;
		repeat (10) @(posedge clk_in);
		arst_n_in <= 1'b1;
		for (int i = 0; i < 150; i++) begin
			r = xs();
			// Bias file addresses to the top end (7F), the PC and the port
			f = r[9] ? r[22:16] : (r[10] ? 7'h06 : (r[11] ? 7'h02 : 7'h7F));
			case (r[1:0])
				2'h0: w = {2'h0, r[5:2] | 4'h2, r[6], f};
				2'h1: w = {2'h1, r[3:2], r[6:4], f};
				2'h2: w = {2'h2, r[13:2]};
				default: w = {2'h3, r[13:2]};
			endcase
			// A true skip only follows a skip test, never a plain word
			put(w, 1'b0, 1);
			if (w[13:12] == 2'h2 || (w[13:12] == 2'h0 && f == 7'h02 && w[7])) begin
				exp_nops++;
				put(cifd_pkg::NOP_WORD, 1'b0, 0);
			end else if (w[13:12] == 2'h1 && w[11]) begin
				exp_nops += r[30];
				put(cifd_pkg::NOP_WORD, r[30], !r[30]);
			end
		end
		repeat (3) put(cifd_pkg::NOP_WORD, 1'b0, 1);
		repeat (12) @(posedge clk_in);
		chk(q.size(), 0);
		chk(nops, exp_nops);
		chk(rd_cnt, exp_rd);
		chk(bad_wr, 0);
		final_report();
	end
	// Hang guard, well beyond the roughly 900 clocks (about 210 instruction cycles) of traffic
	initial begin
		repeat (5000) @(posedge clk_in);
		error_cnt++;
		final_report();
	end
endmodule : core_instruction_field_decode_tb
